/* File: common/rf_cfg_regs.svh */
// Register offsets, field positions, reset values and factor codes of the RF channel and IF block
`ifndef RF_CFG_REGS_SVH
`define RF_CFG_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_IF_HI       8'h0A
`define OFS_IF_LO       8'h0B
`define OFS_CCA_IF_HI   8'h0C
`define OFS_FLT_HI      8'h0E
`define OFS_FLT_LO      8'h0F
`define OFS_CCA_FLT_HI  8'h10
`define OFS_CCA_FLT_LO  8'h11
`define OFS_TRIM        8'h1E
`define OFS_CH_EN_LO    8'h2E
`define OFS_CH_EN_HI    8'h2F
`define OFS_AFC_IF_HI   8'h30
`define OFS_AFC_IF_LO   8'h31
`define OFS_AFC_FLT_HI  8'h32
`define OFS_AFC_FLT_LO  8'h33
`define OFS_DATA_CFG    8'h47
`define OFS_BASE_FL     8'h48
`define OFS_BASE_FM     8'h49
`define OFS_BASE_FH     8'h4A
`define OFS_BASE_NA     8'h4B
`define OFS_SPC_LO      8'h4C
`define OFS_SPC_HI      8'h4D
`define OFS_DEV_LO      8'h4E
`define OFS_DEV_HI      8'h4F
`define OFS_CCA_IF_LO   8'h57
`define OFS_CHAN_SEL    8'h6B

// ****************************************
// Field positions
// ****************************************
`define POS_GFSK        4
`define POS_NARROW      7
`define POS_TRIM_POL    7

// ****************************************
// Reset values
// ****************************************
`define RST_IF_WORD     16'h1447
`define RST_FLT_WORD    16'h024A
`define RST_DATA_CFG    8'h11
`define RST_CH_EN       8'hFF

// ****************************************
// Rate codes and IF multiplication factors
// ****************************************
`define RATE_50K        3'h0
`define RATE_100K       3'h1
`define RATE_150K       3'h2
`define RATE_200K       3'h3
`define RATE_400K       3'h4
`define FACT_X1         4'h1
`define FACT_X2         4'h2
`define FACT_X4         4'h4
`define FACT_X6         4'h6
`define FACT_X8         4'h8

`endif

/* File: common/rf_cfg_pkg.sv */
// Types shared by the RF channel and IF configuration block
package rf_cfg_pkg;

  // Which receive setting set is in use
  typedef enum logic [1:0] {MODE_NORMAL, MODE_AFC, MODE_CCA} rx_mode_t;

  // Complete state of the configuration block
  typedef struct packed {
    logic [7:0]  ch_en_lo;
    logic [7:0]  ch_en_hi;
    logic [7:0]  afc_if_hi;
    logic [7:0]  afc_if_lo;
    logic [7:0]  afc_flt_hi;
    logic [7:0]  afc_flt_lo;
    logic [7:0]  base_fl;
    logic [7:0]  base_fm;
    logic [7:0]  base_fh;
    logic [7:0]  base_na;
    logic [7:0]  spc_lo;
    logic [7:0]  spc_hi;
    logic [7:0]  dev_lo;
    logic [7:0]  dev_hi;
    logic [7:0]  chan_sel;
    logic [7:0]  if_hi;
    logic [7:0]  if_lo;
    logic [7:0]  cca_if_hi;
    logic [7:0]  cca_if_lo;
    logic [7:0]  flt_hi;
    logic [7:0]  flt_lo;
    logic [7:0]  cca_flt_hi;
    logic [7:0]  cca_flt_lo;
    logic [7:0]  data_cfg;
    logic [7:0]  trim_s1;
    logic [7:0]  trim_s2;
    logic [7:0]  rdata;
    logic [5:0]  synth_n;
    logic [1:0]  synth_a;
    logic [19:0] synth_f;
    logic        chan_ok;
    logic [19:0] if_scaled;
    logic [15:0] filter_word;
    logic [15:0] dev_word;
    logic        gaussian_fsk_enable;
    rx_mode_t    mode;
  } cfg_state_t;

endpackage : rf_cfg_pkg

/* File: verilog/if_factor_scaler.sv */
// IF word multiplier with the rate and narrowband factor table
`include "rf_cfg_regs.svh"

module if_factor_scaler #(
  parameter int WORD_W = 16,
  parameter int FACT_W = 4
) (
  // Setting in
  input  wire logic [WORD_W-1:0]        if_word,
  input  wire logic [2:0]               rate,
  input  wire logic                     narrowband,
  input  wire logic                     cca,
  // Scaled word out
  output logic      [WORD_W+FACT_W-1:0] scaled
);

  logic [FACT_W-1:0] factor;

  // Factor lookup; narrowband only exists at 50, 100 and 200 kbps
  always_comb begin
    factor = FACT_W'(`FACT_X1);
    unique case (rate)
      `RATE_50K: begin
        factor = FACT_W'(`FACT_X2);
      end
      `RATE_100K: begin
        if (narrowband) begin
          factor = FACT_W'(`FACT_X2);
        end else begin
          factor = cca ? FACT_W'(`FACT_X6) : FACT_W'(`FACT_X4);
        end
      end
      `RATE_150K: begin
        factor = cca ? FACT_W'(`FACT_X8) : FACT_W'(`FACT_X4);
      end
      `RATE_200K: begin
        if (narrowband) begin
          factor = cca ? FACT_W'(`FACT_X6) : FACT_W'(`FACT_X4);
        end else begin
          factor = cca ? FACT_W'(`FACT_X8) : FACT_W'(`FACT_X6);
        end
      end
      `RATE_400K: begin
        factor = cca ? FACT_W'(`FACT_X8) : FACT_W'(`FACT_X6);
      end
      default: begin
        // Unused rate codes 5 to 7 use the word as programmed
        factor = FACT_W'(`FACT_X1);
      end
    endcase
    scaled = (WORD_W+FACT_W)'(if_word) * (WORD_W+FACT_W)'(factor);
  end

endmodule : if_factor_scaler

/* File: verilog/rf_channel_if_config.sv */
// Channel, IF, filter and deviation configuration registers with derived radio settings
// Register map, all byte wide
// 0A/0B  normal IF word, high/low
// 0C/57  CCA IF word, high/low
// 0E/0F  normal filter word, high/low
// 10/11  CCA filter word, high/low
// 1E     trim pins, read only
// 2E/2F  channel enable mask, low/high
// 30/31  AFC IF word, high/low
// 32/33  AFC filter word, high/low
// 47     data configuration
// 48-4A  base fraction, low to high
// 4B     base N and A counts
// 4C/4D  channel spacing, low/high
// 4E/4F  deviation word, low/high
// 6B     channel select
// Other offsets read zero, drop writes
//
// Data configuration fields
// Bit 7     narrowband select
// Bit 4     Gaussian FSK enable
// Bits 2..0 rate code
//
// Synthesizer word
// Total = (N * 4 + A) * 2^20 + F + channel * spacing
// N is bits 27..22, A 21..20, F 19..0
// Fraction high byte bits 7..4 kept but unused
//
// Receive modes
// CCA wins over AFC; neither means normal
// Mode inputs share this clock, so no sync
//
// Timing
// Writes land at the strobe edge
// Derived outputs follow one edge later
// Read data stand one cycle, zero otherwise
// Trim reads lag the pins by two edges
// No wait states, strobes may run back to back
//
// Limitations
// Filter trim arithmetic is left to software
// Channel plan near reference multiples unchecked
// Narrowband at 150k or 400k gets wideband factor
//
// The plain strobed port was chosen for this implementation.
`include "rf_cfg_regs.svh"

module rf_channel_if_config #(
  parameter int ADDR_W = 8,
  parameter int NUM_CH = 16
) (
  // Clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RESETN,
  // Register port
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [7:0]        REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [7:0]        READ_DATA,
  // Per-chip trim pins and operating modes
  input  wire logic [7:0]        TRIM_IN,
  input  wire logic              AFC_ACTIVE,
  input  wire logic              CCA_ACTIVE,
  // Synthesizer setting
  output logic      [5:0]        SYNTH_N,
  output logic      [1:0]        SYNTH_A,
  output logic      [19:0]       SYNTH_FRAC,
  output logic                   CHANNEL_ENABLED,
  // Receive chain setting
  output logic      [19:0]       RX_IF_WORD,
  output logic      [15:0]       RX_FILTER_WORD,
  output logic      [1:0]        RX_MODE,
  // Modulation setting
  output logic                   GFSK_ENABLE,
  output logic      [15:0]       DEVIATION_WORD
);

  // ****************************************
  // State
  // ****************************************
  rf_cfg_pkg::cfg_state_t state_r;
  rf_cfg_pkg::cfg_state_t state_nxt;

  // Reset image of the whole state
  // Trim stages reset to zero; trim reads are good two edges after release
  localparam rf_cfg_pkg::cfg_state_t STATE_RESET = '{
    ch_en_lo:    `RST_CH_EN,
    ch_en_hi:    `RST_CH_EN,
    afc_if_hi:   8'(`RST_IF_WORD >> 8),
    afc_if_lo:   8'(`RST_IF_WORD),
    afc_flt_hi:  8'(`RST_FLT_WORD >> 8),
    afc_flt_lo:  8'(`RST_FLT_WORD),
    if_hi:       8'(`RST_IF_WORD >> 8),
    if_lo:       8'(`RST_IF_WORD),
    cca_if_hi:   8'(`RST_IF_WORD >> 8),
    cca_if_lo:   8'(`RST_IF_WORD),
    flt_hi:      8'(`RST_FLT_WORD >> 8),
    flt_lo:      8'(`RST_FLT_WORD),
    cca_flt_hi:  8'(`RST_FLT_WORD >> 8),
    cca_flt_lo:  8'(`RST_FLT_WORD),
    data_cfg:    `RST_DATA_CFG,
    mode:        rf_cfg_pkg::MODE_NORMAL,
    default:     '0
  };

  // ****************************************
  // Derived values
  // ****************************************
  logic [3:0]  chan_num;
  logic        chan_in_range;
  logic [15:0] enable_mask;
  logic [15:0] spacing_word;
  logic [19:0] chan_step;
  logic [7:0]  int_count;
  logic [27:0] carrier_sum;
  logic [15:0] if_word_sel;
  logic [19:0] if_scaled;
  logic        narrowband_select;
  logic [2:0]  rate_code;

  // Data configuration fields
  assign rate_code         = state_r.data_cfg[2:0];
  assign narrowband_select = state_r.data_cfg[`POS_NARROW];

  assign chan_num      = state_r.chan_sel[3:0];
  assign chan_in_range = (state_r.chan_sel < 8'(NUM_CH));

  assign enable_mask = {state_r.ch_en_hi, state_r.ch_en_lo};

  // spacing word from its two bytes
  assign spacing_word = {state_r.spc_hi, state_r.spc_lo};

  // channel offset is number times spacing
  // Fifteen full spacing words still fit in 20 bits
  assign chan_step = 20'(spacing_word) * 20'(chan_num);

  // whole count is N times four plus A
  assign int_count = {2'h0, state_r.base_na[7:4], 2'h0} + {4'h0, state_r.base_na[3:0]};

  // fraction bits 19 to 16 come from the high byte low nibble
  // A counts above three carry into N, so the sum re-normalises itself
  assign carrier_sum = {int_count, state_r.base_fh[3:0], state_r.base_fm, state_r.base_fl}
                       + {8'h00, chan_step};

  // Source of the IF word for the current receive mode
  // CCA has priority: an AFC request during CCA is ignored
  always_comb begin
    if (CCA_ACTIVE) begin
      if_word_sel = {state_r.cca_if_hi, state_r.cca_if_lo};
    end else if (AFC_ACTIVE) begin
      if_word_sel = {state_r.afc_if_hi, state_r.afc_if_lo};
    end else begin
      if_word_sel = {state_r.if_hi, state_r.if_lo};
    end
  end

  // one multiplier serves all modes since only one is live at a time
  // CCA steers the factor table as well as the word
  if_factor_scaler #(
    .WORD_W (16),
    .FACT_W (4)
  ) u_scaler (
    .if_word    (if_word_sel),
    .rate       (rate_code),
    .narrowband (narrowband_select),
    .cca        (CCA_ACTIVE),
    .scaled     (if_scaled)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_nxt = state_r;

    // trim pins settle through two flops before anyone reads them
    state_nxt.trim_s1 = TRIM_IN;
    state_nxt.trim_s2 = state_r.trim_s1;

    // Register writes; the trim register is read only
    if (REG_WR) begin
      unique case (REG_ADDR)
        `OFS_IF_HI:      state_nxt.if_hi      = REG_WDATA;
        `OFS_IF_LO:      state_nxt.if_lo      = REG_WDATA;
        `OFS_CCA_IF_HI:  state_nxt.cca_if_hi  = REG_WDATA;
        `OFS_CCA_IF_LO:  state_nxt.cca_if_lo  = REG_WDATA;
        `OFS_FLT_HI:     state_nxt.flt_hi     = REG_WDATA;
        `OFS_FLT_LO:     state_nxt.flt_lo     = REG_WDATA;
        `OFS_CCA_FLT_HI: state_nxt.cca_flt_hi = REG_WDATA;
        `OFS_CCA_FLT_LO: state_nxt.cca_flt_lo = REG_WDATA;
        `OFS_CH_EN_LO:   state_nxt.ch_en_lo   = REG_WDATA;
        `OFS_CH_EN_HI:   state_nxt.ch_en_hi   = REG_WDATA;
        `OFS_AFC_IF_HI:  state_nxt.afc_if_hi  = REG_WDATA;
        `OFS_AFC_IF_LO:  state_nxt.afc_if_lo  = REG_WDATA;
        `OFS_AFC_FLT_HI: state_nxt.afc_flt_hi = REG_WDATA;
        `OFS_AFC_FLT_LO: state_nxt.afc_flt_lo = REG_WDATA;
        `OFS_DATA_CFG:   state_nxt.data_cfg   = REG_WDATA;
        `OFS_BASE_FL:    state_nxt.base_fl    = REG_WDATA;
        `OFS_BASE_FM:    state_nxt.base_fm    = REG_WDATA;
        `OFS_BASE_FH:    state_nxt.base_fh    = REG_WDATA;
        `OFS_BASE_NA:    state_nxt.base_na    = REG_WDATA;
        `OFS_SPC_LO:     state_nxt.spc_lo     = REG_WDATA;
        `OFS_SPC_HI:     state_nxt.spc_hi     = REG_WDATA;
        `OFS_DEV_LO:     state_nxt.dev_lo     = REG_WDATA;
        `OFS_DEV_HI:     state_nxt.dev_hi     = REG_WDATA;
        `OFS_CHAN_SEL:   state_nxt.chan_sel   = REG_WDATA;
        default: begin
          // Unmapped or read-only offsets drop the write
        end
      endcase
    end

    // Read data stand for one cycle only, zero otherwise
    state_nxt.rdata = 8'h00;
    if (REG_RD) begin
      unique case (REG_ADDR)
        `OFS_IF_HI:      state_nxt.rdata = state_r.if_hi;
        `OFS_IF_LO:      state_nxt.rdata = state_r.if_lo;
        `OFS_CCA_IF_HI:  state_nxt.rdata = state_r.cca_if_hi;
        `OFS_CCA_IF_LO:  state_nxt.rdata = state_r.cca_if_lo;
        `OFS_FLT_HI:     state_nxt.rdata = state_r.flt_hi;
        `OFS_FLT_LO:     state_nxt.rdata = state_r.flt_lo;
        `OFS_CCA_FLT_HI: state_nxt.rdata = state_r.cca_flt_hi;
        `OFS_CCA_FLT_LO: state_nxt.rdata = state_r.cca_flt_lo;
        // magnitude in 6..0, polarity in 7
        `OFS_TRIM:       state_nxt.rdata = state_r.trim_s2;
        `OFS_CH_EN_LO:   state_nxt.rdata = state_r.ch_en_lo;
        `OFS_CH_EN_HI:   state_nxt.rdata = state_r.ch_en_hi;
        `OFS_AFC_IF_HI:  state_nxt.rdata = state_r.afc_if_hi;
        `OFS_AFC_IF_LO:  state_nxt.rdata = state_r.afc_if_lo;
        `OFS_AFC_FLT_HI: state_nxt.rdata = state_r.afc_flt_hi;
        `OFS_AFC_FLT_LO: state_nxt.rdata = state_r.afc_flt_lo;
        `OFS_DATA_CFG:   state_nxt.rdata = state_r.data_cfg;
        `OFS_BASE_FL:    state_nxt.rdata = state_r.base_fl;
        `OFS_BASE_FM:    state_nxt.rdata = state_r.base_fm;
        `OFS_BASE_FH:    state_nxt.rdata = state_r.base_fh;
        `OFS_BASE_NA:    state_nxt.rdata = state_r.base_na;
        `OFS_SPC_LO:     state_nxt.rdata = state_r.spc_lo;
        `OFS_SPC_HI:     state_nxt.rdata = state_r.spc_hi;
        `OFS_DEV_LO:     state_nxt.rdata = state_r.dev_lo;
        `OFS_DEV_HI:     state_nxt.rdata = state_r.dev_hi;
        `OFS_CHAN_SEL:   state_nxt.rdata = state_r.chan_sel;
        default: begin
          // Unmapped offsets read as zero
          state_nxt.rdata = 8'h00;
        end
      endcase
    end

    // Derived words are registered so every output comes from a flop
    // synthesizer word for the selected channel
    state_nxt.synth_n = carrier_sum[27:22];
    state_nxt.synth_a = carrier_sum[21:20];
    state_nxt.synth_f = carrier_sum[19:0];

    // a number above fifteen or a masked channel is not usable
    // Out-of-range numbers still steer the synthesizer by their low nibble
    state_nxt.chan_ok = chan_in_range & enable_mask[chan_num];

    // Scaled IF word for the receive filters
    state_nxt.if_scaled = if_scaled;

    // Filter pair follows the receive mode; software loads the trimmed values
    if (CCA_ACTIVE) begin
      state_nxt.mode        = rf_cfg_pkg::MODE_CCA;
      state_nxt.filter_word = {state_r.cca_flt_hi, state_r.cca_flt_lo};
    end else if (AFC_ACTIVE) begin
      state_nxt.mode        = rf_cfg_pkg::MODE_AFC;
      state_nxt.filter_word = {state_r.afc_flt_hi, state_r.afc_flt_lo};
    end else begin
      state_nxt.mode        = rf_cfg_pkg::MODE_NORMAL;
      state_nxt.filter_word = {state_r.flt_hi, state_r.flt_lo};
    end

    state_nxt.gaussian_fsk_enable = state_r.data_cfg[`POS_GFSK];

    // deviation word from its two bytes
    state_nxt.dev_word = {state_r.dev_hi, state_r.dev_lo};
  end

  // ****************************************
  // State register
  // ****************************************
  // Synchronous reset keeps the whole image in one clocked process
  // Derived outputs are reloaded by the reset image as well
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      state_r <= STATE_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // All outputs come straight from the state register
  // Register port
  assign READ_DATA       = state_r.rdata;

  // Synthesizer word and channel usability
  assign SYNTH_N         = state_r.synth_n;
  assign SYNTH_A         = state_r.synth_a;
  assign SYNTH_FRAC      = state_r.synth_f;
  assign CHANNEL_ENABLED = state_r.chan_ok;

  // Receive chain
  assign RX_IF_WORD      = state_r.if_scaled;
  assign RX_FILTER_WORD  = state_r.filter_word;
  assign RX_MODE         = state_r.mode;

  // Modulation
  assign GFSK_ENABLE     = state_r.gaussian_fsk_enable;
  assign DEVIATION_WORD  = state_r.dev_word;

endmodule : rf_channel_if_config

/* File: verification/rf_channel_if_config_monitor.sv */
// Port-level assertions for the RF channel and IF configuration block
module rf_channel_if_config_monitor #(
  parameter int ADDR_W = 8,
  parameter int NUM_CH = 16
) (
  // Clock, reset and register port
  input wire logic              CORE_CLK,
  input wire logic              RESETN,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [7:0]        REG_WDATA,
  input wire logic              REG_WR,
  input wire logic              REG_RD,
  input wire logic [7:0]        READ_DATA,
  // Trim pins and modes
  input wire logic [7:0]        TRIM_IN,
  input wire logic              AFC_ACTIVE,
  input wire logic              CCA_ACTIVE,
  // Derived settings
  input wire logic [5:0]        SYNTH_N,
  input wire logic [1:0]        SYNTH_A,
  input wire logic [19:0]       SYNTH_FRAC,
  input wire logic              CHANNEL_ENABLED,
  input wire logic [19:0]       RX_IF_WORD,
  input wire logic [15:0]       RX_FILTER_WORD,
  input wire logic [1:0]        RX_MODE,
  input wire logic              GFSK_ENABLE,
  input wire logic [15:0]       DEVIATION_WORD
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  // ****************************************
  // Mode selection, CCA wins over AFC
  // ****************************************
  property p_cca_mode;
    CCA_ACTIVE |=> RX_MODE == 2'h2;
  endproperty
  a_cca_mode: assert property (p_cca_mode) else $error("mode not cca");
  property p_afc_mode;
    AFC_ACTIVE && !CCA_ACTIVE |=> RX_MODE == 2'h1;
  endproperty
  a_afc_mode: assert property (p_afc_mode) else $error("mode not afc");
  property p_norm_mode;
    !AFC_ACTIVE && !CCA_ACTIVE |=> RX_MODE == 2'h0;
  endproperty
  a_norm_mode: assert property (p_norm_mode) else $error("mode not normal");

  // ****************************************
  // Register port and derived words
  // ****************************************
  property p_sel_readback;
    REG_WR && REG_ADDR == 8'h6B ##1 REG_RD && REG_ADDR == 8'h6B |=> READ_DATA == $past(REG_WDATA, 2);
  endproperty
  a_sel_readback: assert property (p_sel_readback) else $error("channel select readback");
  // Trim reads need the pins steady across both sync stages
  property p_trim_read;
    REG_RD && REG_ADDR == 8'h1E && TRIM_IN == $past(TRIM_IN) && TRIM_IN == $past(TRIM_IN, 2)
      && $past(RESETN) && $past(RESETN, 2) |=> READ_DATA == $past(TRIM_IN);
  endproperty
  a_trim_read: assert property (p_trim_read) else $error("trim read");
  property p_gfsk;
    REG_WR && REG_ADDR == 8'h47 |-> ##2 GFSK_ENABLE == $past(REG_WDATA[4], 2);
  endproperty
  a_gfsk: assert property (p_gfsk) else $error("gfsk enable");
  property p_dev_high;
    REG_WR && REG_ADDR == 8'h4F |-> ##2 DEVIATION_WORD[15:8] == $past(REG_WDATA, 2);
  endproperty
  a_dev_high: assert property (p_dev_high) else $error("deviation high byte");
  property p_chan_range;
    REG_WR && REG_ADDR == 8'h6B && REG_WDATA >= 8'(NUM_CH) |-> ##2 !CHANNEL_ENABLED;
  endproperty
  a_chan_range: assert property (p_chan_range) else $error("channel above fifteen");
endmodule : rf_channel_if_config_monitor

bind rf_channel_if_config rf_channel_if_config_monitor #(.ADDR_W(ADDR_W), .NUM_CH(NUM_CH)) monitor (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .READ_DATA(READ_DATA), .TRIM_IN(TRIM_IN), .AFC_ACTIVE(AFC_ACTIVE),
  .CCA_ACTIVE(CCA_ACTIVE), .SYNTH_N(SYNTH_N), .SYNTH_A(SYNTH_A), .SYNTH_FRAC(SYNTH_FRAC),
  .CHANNEL_ENABLED(CHANNEL_ENABLED), .RX_IF_WORD(RX_IF_WORD), .RX_FILTER_WORD(RX_FILTER_WORD),
  .RX_MODE(RX_MODE), .GFSK_ENABLE(GFSK_ENABLE), .DEVIATION_WORD(DEVIATION_WORD)
);

/* File: verification/test_rf_channel_if_config.sv */
// Self-checking bench for the RF channel and IF configuration block
module test_rf_channel_if_config;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Signals and shadow registers
  // ****************************************
  logic        core_clk;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  read_data;
  logic [7:0]  trim_in;
  logic        afc_active;
  logic        cca_active;
  logic [5:0]  synth_n;
  logic [1:0]  synth_a;
  logic [19:0] synth_frac;
  logic        chan_enabled;
  logic [19:0] rx_if_word;
  logic [15:0] rx_filter_word;
  logic [1:0]  rx_mode;
  logic        gfsk_enable;
  logic [15:0] deviation_word;
  logic [7:0]  shadow [0:127];
  int          err_count;
  int          checked;
  // Hand-picked writes {offset, data}: carrier example, range edges, read-only and unmapped places
  // clear channel plan
  logic [15:0] corner [30] = '{16'h4844, 16'h4944, 16'h4A0A, 16'h4B61, 16'h4C82, 16'h4D2D, 16'h6B0F,
    16'h2F7F, 16'h2F80, 16'h6B10, 16'h6B00, 16'h4BFF, 16'h4AFF, 16'h1E55, 16'h1034, 16'h2E00, 16'h4790,
    16'h4781, 16'h4783, 16'h4702, 16'h4704, 16'h4707, 16'h4E60, 16'h4F0B, 16'h4700, 16'h7F12,
    16'h0E03, 16'h0F4B, 16'h3201, 16'h3344};

  rf_channel_if_config #(.ADDR_W(8), .NUM_CH(16)) dut (
    .CORE_CLK(core_clk), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .READ_DATA(read_data), .TRIM_IN(trim_in),
    .AFC_ACTIVE(afc_active), .CCA_ACTIVE(cca_active), .SYNTH_N(synth_n), .SYNTH_A(synth_a),
    .SYNTH_FRAC(synth_frac), .CHANNEL_ENABLED(chan_enabled), .RX_IF_WORD(rx_if_word),
    .RX_FILTER_WORD(rx_filter_word), .RX_MODE(rx_mode), .GFSK_ENABLE(gfsk_enable),
    .DEVIATION_WORD(deviation_word)
  );

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  // ****************************************
  // Expectation functions
  // ****************************************
  function automatic logic [7:0] rst_val(input logic [7:0] a);
    case (a)
      8'h0A, 8'h0C, 8'h30: return 8'h14;
      8'h0B, 8'h57, 8'h31: return 8'h47;
      8'h0E, 8'h10, 8'h32: return 8'h02;
      8'h0F, 8'h11, 8'h33: return 8'h4A;
      8'h2E, 8'h2F:        return 8'hFF;
      8'h47:               return 8'h11;
      default:             return 8'h00;
    endcase
  endfunction : rst_val

  function automatic bit mapped(input logic [7:0] a);
    return a inside {[8'h0A:8'h0C], [8'h0E:8'h11], [8'h2E:8'h33], [8'h47:8'h4F], 8'h57, 8'h6B};
  endfunction : mapped

  // IF multiplication by rate code, narrowband select and CCA
  function automatic logic [3:0] fac(input logic [2:0] r, input logic nb, input logic cca);
    case (r)
      3'h0:    return 4'h2;
      3'h1:    return cca ? (nb ? 4'h2 : 4'h6) : (nb ? 4'h2 : 4'h4);
      3'h2:    return cca ? 4'h8 : 4'h4;
      3'h3:    return cca ? (nb ? 4'h6 : 4'h8) : (nb ? 4'h4 : 4'h6);
      3'h4:    return cca ? 4'h8 : 4'h6;
      default: return 4'h1;
    endcase
  endfunction : fac

  // ****************************************
  // Compare, bus and check tasks
  // ****************************************
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] a);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: read %h got %h expected %h", $time, a, got, exp);
    end
  endtask : cmp_rd

  task automatic cmp_word(input logic [27:0] got, input logic [27:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_word

  // Starts and ends on a rising edge; read-only and unmapped writes leave the shadow alone
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (mapped(a)) shadow[a] = d;
  endtask : wr

  // Data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd_chk(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    cmp_rd(read_data, a == 8'h1E ? trim_in : shadow[a], a);
    @(posedge core_clk);
  endtask : rd_chk

  task automatic settle_check();
    logic [27:0] total;
    logic [15:0] mask;
    logic [15:0] w;
    logic [15:0] f;
    logic [7:0]  sel;
    logic [7:0]  dc;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    sel = shadow[8'h6B];
    dc = shadow[8'h47];
    mask = {shadow[8'h2F], shadow[8'h2E]};
    total = (28'(shadow[8'h4B][7:4]) << 22) + (28'(shadow[8'h4B][3:0]) << 20)
      + 28'({shadow[8'h4A][3:0], shadow[8'h49], shadow[8'h48]}) + 28'(sel[3:0]) * 28'({shadow[8'h4D], shadow[8'h4C]});
    w = cca_active ? {shadow[8'h0C], shadow[8'h57]} : afc_active ? {shadow[8'h30], shadow[8'h31]}
      : {shadow[8'h0A], shadow[8'h0B]};
    f = cca_active ? {shadow[8'h10], shadow[8'h11]} : afc_active ? {shadow[8'h32], shadow[8'h33]}
      : {shadow[8'h0E], shadow[8'h0F]};
    cmp_word({synth_n, synth_a, synth_frac}, total, "synth");
    cmp_word(28'(chan_enabled), 28'(sel < 8'h10 && mask[sel[3:0]]), "enable");
    cmp_word(28'(rx_mode), cca_active ? 28'h2 : 28'(afc_active), "mode");
    cmp_word(28'(rx_if_word), 28'(w) * 28'(fac(dc[2:0], dc[7], cca_active)), "if");
    cmp_word(28'(rx_filter_word), 28'(f), "filter");
    cmp_word(28'(gfsk_enable), 28'(dc[4]), "gfsk");
    cmp_word(28'(deviation_word), 28'({shadow[8'h4F], shadow[8'h4E]}), "deviation");
    @(posedge core_clk);
  endtask : settle_check

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] a;
    logic [7:0] d;
    core_clk = 1'b0;
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    afc_active = 1'b0;
    cca_active = 1'b0;
    err_count = 0;
    checked = 0;
    void'($urandom(32'h5E3694F9));
    trim_in = 8'($urandom);
    for (int i = 0; i < 128; i++) shadow[i] = rst_val(8'(i));
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    // Reset image of offsets 00 to 7F, then the derived words it implies
    for (int i = 0; i < 128; i++) rd_chk(8'(i));
    settle_check();
    // Each corner write is read back and judged in all four mode combinations
    foreach (corner[j]) begin
      wr(corner[j][15:8], corner[j][7:0]);
      rd_chk(corner[j][15:8]);
      for (int m = 0; m < 4; m++) begin
        cca_active <= m[1];
        afc_active <= m[0];
        settle_check();
      end
    end
    for (int n = 0; n < 300; n++) begin
      a = 8'($urandom_range(0, 111));
      d = 8'($urandom);
      if (a == 8'h47 && !(d[2:0] inside {3'h0, 3'h1, 3'h3})) d[7] = 1'b0;
      if (n % 50 == 0) begin
        trim_in <= 8'($urandom);
        repeat (3) @(posedge core_clk);
      end
      wr(a, d);
      rd_chk(a);
      cca_active <= 1'($urandom);
      afc_active <= 1'($urandom);
      settle_check();
    end
    report_and_stop();
  end

  // Guard against a hung run
  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    report_and_stop();
  end
endmodule : test_rf_channel_if_config
